// >>> rtl/line_cfg_pkg.sv
package line_cfg_pkg;

  // register offsets
  localparam logic [7:0] MODE_OFFSET        = 8'h04;
  localparam logic [7:0] CONTROL_OFFSET     = 8'h06;
  localparam logic [7:0] CQ_CFG_OFFSET      = 8'h07;
  localparam logic [7:0] DIO_CFG_OFFSET     = 8'h08;
  localparam logic [7:0] CLK_CFG_OFFSET     = 8'h09;
  localparam logic [7:0] TRIM_OFFSET        = 8'h0a;
  localparam logic [7:0] REV_OFFSET         = 8'h0c;

  // reset values
  localparam logic [7:0] CQ_CFG_RESET       = 8'h00;
  localparam logic [7:0] DIO_CFG_RESET      = 8'h00;
  localparam logic [7:0] CLK_CFG_RESET      = 8'h00;
  localparam logic [7:0] TRIM_RESET         = 8'h00;
  localparam logic [7:0] CONTROL_RESET      = 8'h00;

  // driver configuration fields (same layout for both lines)
  localparam int SLEW_HI_BIT      = 7;
  localparam int SLEW_LO_BIT      = 6;
  localparam int WEAK_SINK_BIT    = 5;
  localparam int WEAK_SOURCE_BIT  = 4;
  localparam int LOW_SIDE_BIT     = 3;
  localparam int PUSH_PULL_BIT    = 2;
  localparam int SAME_POL_BIT     = 1;
  localparam int DRIVER_EN_BIT    = 0;

  // control / mode fields
  localparam int LINE_A_SW_BIT    = 0;
  localparam int LINE_B_SW_BIT    = 1;
  localparam int SOFT_RESET_BIT   = 7;
  localparam logic [7:0] CONTROL_MASK = 8'h03;

  // clock configuration fields
  localparam int FINE_TRIM_EN_BIT = 7;
  localparam int DIV_HI_BIT       = 2;
  localparam int DIV_LO_BIT       = 1;
  localparam int CLOCK_OFF_BIT    = 0;
  localparam logic [7:0] CLK_CFG_MASK = 8'h87;
  localparam logic [7:0] TRIM_MASK    = 8'h3f;

  // slew codes, in ns, for the analog driver
  localparam int SLEW_00_NS = 250;
  localparam int SLEW_01_NS = 500;
  localparam int SLEW_10_NS = 1250;
  localparam int SLEW_11_NS = 5000;

  // clock generation: phase accumulator step = f_out * 2^32 / f_sys
  localparam longint unsigned SYS_CLK_HZ = 250_000_000;
  localparam longint unsigned UC_CLK_00_HZ = 3_686_400;
  localparam longint unsigned UC_CLK_01_HZ = 7_372_800;
  localparam longint unsigned UC_CLK_10_HZ = 14_745_600;
  localparam longint unsigned UC_CLK_11_HZ = 1_843_200;
  localparam logic [63:0] STEP_00 = (UC_CLK_00_HZ << 32) / SYS_CLK_HZ;
  localparam logic [63:0] STEP_01 = (UC_CLK_01_HZ << 32) / SYS_CLK_HZ;
  localparam logic [63:0] STEP_10 = (UC_CLK_10_HZ << 32) / SYS_CLK_HZ;
  localparam logic [63:0] STEP_11 = (UC_CLK_11_HZ << 32) / SYS_CLK_HZ;

  // trim slope per code, scaled by 2^16: ~0.177 %/code slower, ~0.021 %/code faster
  localparam logic [7:0] TRIM_SLOW_PER_CODE = 8'h74;
  localparam logic [7:0] TRIM_FAST_PER_CODE = 8'h0e;
  localparam int         TRIM_SCALE_SHIFT   = 16;

endpackage : line_cfg_pkg

// >>> rtl/uc_clock_gen.sv
`timescale 1ns/1ps
module uc_clock_gen #(
  parameter int ACC_W = 32
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic [1:0] div_sel_in,
  input  wire logic       clock_off_in,
  input  wire logic       trim_en_in,
  input  wire logic [5:0] trim_in,
  output logic            uc_clock_out
);

  if (ACC_W != 32)
  begin : g_bad_width
    $error("uc_clock_gen: ACC_W must be 32");
  end

  typedef struct packed {
    logic [31:0] phase;
    logic        clk;
  } gen_state_t;

  gen_state_t st;
  gen_state_t next_st;

  logic [31:0] base_step;
  logic [31:0] step;
  logic [5:0]  mag;
  logic [7:0]  slope;
  logic [47:0] delta;

  always_comb
  begin
    unique case (div_sel_in)
      2'b00: base_step = line_cfg_pkg::STEP_00[31:0];
      2'b01: base_step = line_cfg_pkg::STEP_01[31:0];
      2'b10: base_step = line_cfg_pkg::STEP_10[31:0];
      2'b11: base_step = line_cfg_pkg::STEP_11[31:0];
    endcase
    // negative codes speed up, positive slow down; slopes differ per side
    mag   = trim_in[5] ? 6'(-trim_in) : trim_in; // RL17
    slope = trim_in[5] ? line_cfg_pkg::TRIM_FAST_PER_CODE
                       : line_cfg_pkg::TRIM_SLOW_PER_CODE;
    delta = ({16'h0000, base_step} * {42'h0, mag} * {40'h0, slope})
            >> line_cfg_pkg::TRIM_SCALE_SHIFT;
    if (!trim_en_in) // RL16
      step = base_step;
    else if (trim_in[5])
      step = base_step + delta[31:0]; // RL17
    else
      step = base_step - delta[31:0]; // RL17
    next_st = st;
    if (clock_off_in)
    begin
      // pin keeps driving low while stopped, never floats
      next_st.phase = 32'h0000_0000;
      next_st.clk   = 1'b0; // RL15
    end
    else
    begin
      next_st.phase = st.phase + step; // RL13
      next_st.clk   = st.phase[31];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      st <= '0;
    else if (ce_in)
      st <= next_st;
  end

  assign uc_clock_out = st.clk;

endmodule : uc_clock_gen

// >>> rtl/line_driver_and_clock_config.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] line a slew field bits 7:6 selects 250ns, 500ns, 1.25us or 5us
// [RL2] line b slew field bits 7:6 selects the same four edge rates
// [RL3] line a: push-pull bit wins, else low-side bit picks low or high side
// [RL4] line b: push-pull bit wins, else low-side bit picks low or high side
// [RL5] line a bits 5 and 4 enable weak sink and weak source
// [RL6] line b bits 5 and 4 enable weak sink and weak source
// [RL7] line a polarity bit 1 inverts line versus transmit and receive
// [RL8] line b polarity bit 1 inverts line versus local pin and sw bit
// [RL9] line a enable low: driver off in every topology, receive only
// [RL10] line b enable: driver on, receiver off, local pin input; else reverse
// [RL11] line a truth table from transmit enable, transmit data and sw bit
// [RL12] line b truth table from local pin and sw bit
// [RL13] clock divider code picks 3.686, 7.373, 14.74 or 1.843 MHz
// [RL14] after reset the microcontroller clock runs at 3.686 MHz
// [RL15] clock off bit stops the clock, pin stays actively driven
// [RL16] fine trim enable gates whether the trim value acts
// [RL17] trim is signed six bits: -32 faster, 0 nominal, +31 slower
// [RL18] read-only revision register returns a fixed code, ignores writes
// [RL19] line a software bit in control register feeds the line a table
// [RL20] writing the soft reset bit restores defaults and clears itself
// [RL21] unused clock config and trim bits read zero and ignore writes
// [RL22] config fields hold until rewritten or reset; reads have no effect
module line_driver_and_clock_config #(
  parameter logic [7:0] REVISION_CODE = 8'h5a  // value is arbitrary
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       transmit_enable_pin_in,
  input  wire logic       tx_in,
  input  wire logic       line_a_level_in,
  output logic            rx_out,
  output logic            line_a_drive_high_out,
  output logic            line_a_drive_low_out,
  output logic            line_a_weak_sink_en_out,
  output logic            line_a_weak_source_en_out,
  output logic      [1:0] line_a_slew_sel_out,
  input  wire logic       line_b_level_in,
  input  wire logic       line_b_local_pin_in,
  output logic            line_b_local_pin_out,
  output logic            line_b_local_pin_oe_out,
  output logic            line_b_receiver_en_out,
  output logic            line_b_drive_high_out,
  output logic            line_b_drive_low_out,
  output logic            line_b_weak_sink_en_out,
  output logic            line_b_weak_source_en_out,
  output logic      [1:0] line_b_slew_sel_out,
  output logic            uc_clock_out
);

  localparam int SYNC_W = 5;
  localparam int S_GATE = 0;
  localparam int S_TX   = 1;
  localparam int S_LA   = 2;
  localparam int S_LB   = 3;
  localparam int S_LOC  = 4;

  typedef struct packed {
    logic [7:0]        cq_driver_config;
    logic [7:0]        dio_driver_config;
    logic [7:0]        clock_output_config;
    logic [7:0]        clock_fine_trim;
    logic [7:0]        control;
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_pin;
    logic [7:0]        rdata;
    logic              rx;
    logic              a_high;
    logic              a_low;
    logic              b_high;
    logic              b_low;
    logic              b_loc;
    logic              b_loc_oe;
    logic              b_rx_en;
  } cfg_state_t;

  cfg_state_t st;
  cfg_state_t next_st;

  logic [SYNC_W-1:0] pins_raw;
  logic              a_en;
  logic              a_low_side;
  logic              a_push_pull;
  logic              a_want_low;
  logic              b_en;
  logic              b_low_side;
  logic              b_push_pull;
  logic              b_want_low;
  logic              can_sink_a;
  logic              can_source_a;
  logic              can_sink_b;
  logic              can_source_b;

  assign pins_raw = {line_b_local_pin_in, line_b_level_in, line_a_level_in,
                     tx_in, transmit_enable_pin_in};

  always_comb
  begin
    next_st = st;
    // first stage feeds only the second stage
    next_st.sync_meta = pins_raw;
    next_st.sync_pin  = st.sync_meta;

    // register writes; unmapped and read-only offsets drop the write
    if (reg_wr_in) // RL22
    begin
      unique case (reg_addr_in)
        line_cfg_pkg::CQ_CFG_OFFSET:
          next_st.cq_driver_config = reg_wdata_in;
        line_cfg_pkg::DIO_CFG_OFFSET:
          next_st.dio_driver_config = reg_wdata_in;
        line_cfg_pkg::CLK_CFG_OFFSET:
          next_st.clock_output_config =
            reg_wdata_in & line_cfg_pkg::CLK_CFG_MASK; // RL21
        line_cfg_pkg::TRIM_OFFSET:
          next_st.clock_fine_trim =
            reg_wdata_in & line_cfg_pkg::TRIM_MASK; // RL21
        line_cfg_pkg::CONTROL_OFFSET:
          next_st.control = reg_wdata_in & line_cfg_pkg::CONTROL_MASK;
        line_cfg_pkg::MODE_OFFSET:
          // reset bit is never stored, so it reads back cleared
          if (reg_wdata_in[line_cfg_pkg::SOFT_RESET_BIT]) // RL20
          begin
            next_st.cq_driver_config    = line_cfg_pkg::CQ_CFG_RESET;
            next_st.dio_driver_config   = line_cfg_pkg::DIO_CFG_RESET;
            next_st.clock_output_config = line_cfg_pkg::CLK_CFG_RESET;
            next_st.clock_fine_trim     = line_cfg_pkg::TRIM_RESET;
            next_st.control             = line_cfg_pkg::CONTROL_RESET;
          end
        default:
          next_st.rdata = st.rdata;
      endcase
    end

    // read data is registered; reads change nothing else
    if (reg_rd_in) // RL22
    begin
      unique case (reg_addr_in)
        line_cfg_pkg::CQ_CFG_OFFSET:  next_st.rdata = st.cq_driver_config;
        line_cfg_pkg::DIO_CFG_OFFSET: next_st.rdata = st.dio_driver_config;
        line_cfg_pkg::CLK_CFG_OFFSET: next_st.rdata = st.clock_output_config;
        line_cfg_pkg::TRIM_OFFSET:    next_st.rdata = st.clock_fine_trim;
        line_cfg_pkg::CONTROL_OFFSET: next_st.rdata = st.control;
        line_cfg_pkg::REV_OFFSET:     next_st.rdata = REVISION_CODE; // RL18
        default:                      next_st.rdata = 8'h00;
      endcase
    end

    // line a: driver decode from registered config and synced pins
    a_en        = st.cq_driver_config[line_cfg_pkg::DRIVER_EN_BIT];
    a_push_pull = st.cq_driver_config[line_cfg_pkg::PUSH_PULL_BIT];
    a_low_side  = st.cq_driver_config[line_cfg_pkg::LOW_SIDE_BIT];
    can_sink_a   = a_push_pull | a_low_side;    // RL3
    can_source_a = a_push_pull | ~a_low_side;   // RL3
    a_want_low = st.sync_pin[S_TX] &
                 ~st.control[line_cfg_pkg::LINE_A_SW_BIT]; // RL11 RL19
    if (st.cq_driver_config[line_cfg_pkg::SAME_POL_BIT])
      a_want_low = ~a_want_low; // RL7
    // transmit enable low or driver off: both switches open
    next_st.a_low  = a_en & st.sync_pin[S_GATE] & a_want_low
                     & can_sink_a; // RL9 RL11
    next_st.a_high = a_en & st.sync_pin[S_GATE] & ~a_want_low
                     & can_source_a; // RL9 RL11
    next_st.rx = st.cq_driver_config[line_cfg_pkg::SAME_POL_BIT]
                 ? st.sync_pin[S_LA] : ~st.sync_pin[S_LA]; // RL7

    // line b: local pin is the data source while driving
    b_en        = st.dio_driver_config[line_cfg_pkg::DRIVER_EN_BIT];
    b_push_pull = st.dio_driver_config[line_cfg_pkg::PUSH_PULL_BIT];
    b_low_side  = st.dio_driver_config[line_cfg_pkg::LOW_SIDE_BIT];
    can_sink_b   = b_push_pull | b_low_side;    // RL4
    can_source_b = b_push_pull | ~b_low_side;   // RL4
    b_want_low = st.sync_pin[S_LOC] &
                 ~st.control[line_cfg_pkg::LINE_B_SW_BIT]; // RL12
    if (st.dio_driver_config[line_cfg_pkg::SAME_POL_BIT])
      b_want_low = ~b_want_low; // RL8
    next_st.b_low  = b_en & b_want_low & can_sink_b;    // RL10 RL12
    next_st.b_high = b_en & ~b_want_low & can_source_b; // RL10 RL12
    next_st.b_rx_en  = ~b_en; // RL10
    next_st.b_loc_oe = ~b_en; // RL10
    next_st.b_loc = st.dio_driver_config[line_cfg_pkg::SAME_POL_BIT]
                    ? st.sync_pin[S_LB] : ~st.sync_pin[S_LB]; // RL8
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      st <= '0; // RL14
    else if (ce_in)
      st <= next_st;
  end

  // slew and weak-current controls go straight out of the config flops
  assign line_a_slew_sel_out = // RL1
    st.cq_driver_config[line_cfg_pkg::SLEW_HI_BIT:line_cfg_pkg::SLEW_LO_BIT];
  assign line_b_slew_sel_out = // RL2
    st.dio_driver_config[line_cfg_pkg::SLEW_HI_BIT:line_cfg_pkg::SLEW_LO_BIT];
  assign line_a_weak_sink_en_out =
    st.cq_driver_config[line_cfg_pkg::WEAK_SINK_BIT]; // RL5
  assign line_a_weak_source_en_out =
    st.cq_driver_config[line_cfg_pkg::WEAK_SOURCE_BIT]; // RL5
  assign line_b_weak_sink_en_out =
    st.dio_driver_config[line_cfg_pkg::WEAK_SINK_BIT]; // RL6
  assign line_b_weak_source_en_out =
    st.dio_driver_config[line_cfg_pkg::WEAK_SOURCE_BIT]; // RL6

  assign reg_rdata_out           = st.rdata;
  assign rx_out                  = st.rx;
  assign line_a_drive_high_out   = st.a_high;
  assign line_a_drive_low_out    = st.a_low;
  assign line_b_drive_high_out   = st.b_high;
  assign line_b_drive_low_out    = st.b_low;
  assign line_b_local_pin_out    = st.b_loc;
  assign line_b_local_pin_oe_out = st.b_loc_oe;
  assign line_b_receiver_en_out  = st.b_rx_en;

  // every setting is a phase accumulator, so edges jitter by a cycle
  uc_clock_gen #(
    .ACC_W (32)
  ) u_clock (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .ce_in        (ce_in),
    .div_sel_in   (st.clock_output_config[line_cfg_pkg::DIV_HI_BIT:
                                          line_cfg_pkg::DIV_LO_BIT]),
    .clock_off_in (st.clock_output_config[line_cfg_pkg::CLOCK_OFF_BIT]),
    .trim_en_in   (st.clock_output_config[line_cfg_pkg::FINE_TRIM_EN_BIT]),
    .trim_in      (st.clock_fine_trim[5:0]),
    .uc_clock_out (uc_clock_out)
  ); // RL13 RL15 RL16

endmodule : line_driver_and_clock_config

// >>> verif/line_cfg_monitor.sv
`timescale 1ns/1ps
module line_cfg_monitor #(
  parameter logic [7:0] REVISION_CODE = 8'h00
) (
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  input wire logic       ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       transmit_enable_pin_in,
  input wire logic       line_a_drive_high_out,
  input wire logic       line_a_drive_low_out,
  input wire logic [1:0] line_a_slew_sel_out,
  input wire logic       line_b_receiver_en_out,
  input wire logic       line_b_local_pin_oe_out,
  input wire logic       line_b_drive_high_out,
  input wire logic       line_b_drive_low_out,
  input wire logic       line_b_weak_sink_en_out,
  input wire logic       uc_clock_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in || !ce_in);

  no_short_a: assert property (
    !(line_a_drive_high_out && line_a_drive_low_out))
    else $error("line a drives both switches");
  // pin passes two sync flops and one output flop
  transmit_enable_pin_gate_a: assert property (
    !$past(transmit_enable_pin_in, 3) |->
      !line_a_drive_high_out && !line_a_drive_low_out)
    else $error("line a driven with transmit enable low");
  slew_follow_a: assert property (
    reg_wr_in && reg_addr_in == 8'h07 |->
      ##2 line_a_slew_sel_out == $past(reg_wdata_in[7:6], 2))
    else $error("line a slew not taken from write");
  sink_follow_a: assert property (
    reg_wr_in && reg_addr_in == 8'h08 |->
      ##2 line_b_weak_sink_en_out == $past(reg_wdata_in[5], 2))
    else $error("line b sink not taken from write");
  rev_read_a: assert property (
    reg_rd_in && reg_addr_in == 8'h0c |=> reg_rdata_out == REVISION_CODE)
    else $error("revision read wrong");
  trim_top_a: assert property (
    reg_rd_in && reg_addr_in == 8'h0a |=> reg_rdata_out[7:6] == 2'b00)
    else $error("unused trim bits not zero");
  rdata_hold_a: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  clk_stop_a: assert property (
    reg_wr_in && reg_addr_in == 8'h09 && reg_wdata_in[0] |->
      ##2 (!uc_clock_out) [*8])
    else $error("clock kept running after stop");
  rx_exclusive_a: assert property (
    line_b_receiver_en_out == line_b_local_pin_oe_out &&
    (!line_b_receiver_en_out ||
      (!line_b_drive_high_out && !line_b_drive_low_out)))
    else $error("line b receiver and driver overlap");

  cover property (line_a_drive_low_out);
  cover property (line_b_drive_high_out);
  cover property (reg_rd_in && reg_addr_in == 8'h0c);
endmodule : line_cfg_monitor

bind line_driver_and_clock_config line_cfg_monitor #(
  .REVISION_CODE(REVISION_CODE)
) mon (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .transmit_enable_pin_in(transmit_enable_pin_in),
  .line_a_drive_high_out(line_a_drive_high_out),
  .line_a_drive_low_out(line_a_drive_low_out),
  .line_a_slew_sel_out(line_a_slew_sel_out),
  .line_b_receiver_en_out(line_b_receiver_en_out),
  .line_b_local_pin_oe_out(line_b_local_pin_oe_out),
  .line_b_drive_high_out(line_b_drive_high_out),
  .line_b_drive_low_out(line_b_drive_low_out),
  .line_b_weak_sink_en_out(line_b_weak_sink_en_out),
  .uc_clock_out(uc_clock_out)
);

// >>> verif/uc_host_model.sv
`timescale 1ns/1ps
module uc_host_model (
  input  wire logic sys_clk_in,
  input  wire logic uc_clock_in,
  output logic      tx_gate_out,
  output logic      tx_out
);
  initial
  begin
    tx_gate_out = 1'b0;
    tx_out   = 1'b1;
  end

  task automatic drive(input logic en, input logic d);
    @(negedge sys_clk_in);
    tx_gate_out = en;
    tx_out   = d;
  endtask : drive

  // uart baud comes from this clock; first partial period is skipped
  task automatic measure(input int n, output int cyc);
    int   e;
    logic p;
    e = 0;
    cyc = 0;
    p = uc_clock_in;
    for (int k = 0; k < 300 * n && e <= n; k++)
    begin
      @(negedge sys_clk_in);
      if (e > 0)
        cyc++;
      if (uc_clock_in && !p)
        e++;
      p = uc_clock_in;
    end
  endtask : measure
endmodule : uc_host_model

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] REV = 8'h3c;  // value is arbitrary
  logic       clk, rst, ce, wr, rd, tgate, tx, la_lvl, rx, ahi, alo;
  logic       asink, asrc, lb_lvl, lb_pin, lpo, loe, bhi, blo;
  logic       bsink, bsrc, ucclk, rxen;
  logic [1:0] aslew, bslew;
  logic [7:0] addr, wdata, rdata, d, e;
  int         miscompares = 0, checked = 0, cyc = 0, n;
  real        fq [4] = '{3.686, 7.373, 14.74, 1.843};
  logic [7:0] ra [5] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0c};
  logic [7:0] wa [5] = '{8'h07, 8'h09, 8'h0a, 8'h0c, 8'h0b};
  logic [7:0] wv [5] = '{8'ha5, 8'hff, 8'hff, 8'h00, 8'h55};
  logic [7:0] we [5] = '{8'ha5, 8'h87, 8'h3f, REV, 8'h00};

  line_driver_and_clock_config #(.REVISION_CODE(REV)) dut (
    .sys_clk_in(clk), .rst_in(rst), .ce_in(ce), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .transmit_enable_pin_in(tgate), .tx_in(tx),
    .line_a_level_in(la_lvl), .rx_out(rx), .line_a_drive_high_out(ahi),
    .line_a_drive_low_out(alo), .line_a_weak_sink_en_out(asink),
    .line_a_weak_source_en_out(asrc), .line_a_slew_sel_out(aslew),
    .line_b_level_in(lb_lvl), .line_b_local_pin_in(lb_pin),
    .line_b_local_pin_out(lpo), .line_b_local_pin_oe_out(loe),
    .line_b_receiver_en_out(rxen), .line_b_drive_high_out(bhi),
    .line_b_drive_low_out(blo), .line_b_weak_sink_en_out(bsink),
    .line_b_weak_source_en_out(bsrc), .line_b_slew_sel_out(bslew),
    .uc_clock_out(ucclk));

  uc_host_model host (.sys_clk_in(clk), .uc_clock_in(ucclk),
    .tx_gate_out(tgate), .tx_out(tx));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [1:0] drv(logic en, logic in, logic sw,
                                     logic pol, logic pp, logic ls);
    logic lo;
    lo = (in & ~sw) ^ pol;
    return {en & ~lo & (pp | ~ls), en & lo & (pp | ls)};
  endfunction : drv

  function automatic int per(real f);
    return $rtoi(64.0 * 250.0 / f);
  endfunction : per

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    v = rdata;
  endtask : rd_reg

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // clock counts get a small margin for accumulator jitter
  task automatic chkn(input int got, input int exp);
    checked++;
    if (got > exp + exp / 400 + 2 || got < exp - exp / 400 - 2)
    begin
      miscompares++;
      $display("unexpected at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask : chkn

  task automatic done(input string s);
    $display("test %s done at %0t", s, $time);
  endtask : done

  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      summarize();
    end
  end

  initial
  begin
    {rst, ce, wr, rd, la_lvl, lb_lvl, lb_pin} = 7'b1100000;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      rd_reg(ra[k], d);
      chk(d, k == 4 ? REV : 8'h00);
    end
    host.measure(64, n);
    chkn(n, per(fq[0]));
    done("reset");
    for (int k = 0; k < 5; k++)
    begin
      wr_reg(wa[k], wv[k]);
      rd_reg(wa[k], d);
      chk(d, we[k]);
    end
    rd_reg(8'h07, d);
    chk(d, 8'ha5);
    wr_reg(8'h04, 8'h80);
    for (int k = 0; k < 4; k++)
    begin
      rd_reg(ra[k], d);
      chk(d, 8'h00);
    end
    done("registers");
    for (int i = 0; i < 128; i++)
    begin
      wr_reg(8'h07, {i[1:0], i[0], ~i[0], i[5:3], i[6]});
      wr_reg(8'h06, {7'h00, i[0]});
      host.drive(i[2], i[1]);
      la_lvl = i[5];
      repeat (4) @(negedge clk);
      e = {1'b0, drv(i[6] & i[2], i[1], i[0], i[3], i[4], i[5]),
           i[5] ~^ i[3], i[1:0], i[0], ~i[0]};
      chk({1'b0, ahi, alo, rx, aslew, asink, asrc},
          e);
    end
    done("line a");
    for (int i = 0; i < 64; i++)
    begin
      wr_reg(8'h08, {i[1:0], i[1], ~i[1], i[4:2], i[5]});
      wr_reg(8'h06, {6'h00, i[0], 1'b0});
      lb_pin = i[1];
      lb_lvl = i[3];
      repeat (4) @(negedge clk);
      e = {drv(i[5], i[1], i[0], i[2], i[3], i[4]),
           ~i[5] & (i[3] ~^ i[2]), ~i[5], i[1:0], i[1], ~i[1]};
      chk({bhi, blo, lpo & loe, loe, bslew, bsink, bsrc},
          e);
      chk({7'h00, rxen}, {7'h00, ~i[5]});
    end
    done("line b");
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(8'h09, {5'h00, k[1:0], 1'b0});
      host.measure(64, n);
      chkn(n, per(fq[k]));
    end
    wr_reg(8'h09, 8'h00);
    wr_reg(8'h0a, 8'h1f);
    host.measure(64, n);
    chkn(n, per(fq[0]));
    wr_reg(8'h09, 8'h80);
    host.measure(64, n);
    chkn(n, $rtoi(per(fq[0]) / 0.945));
    wr_reg(8'h0a, 8'h20);
    host.measure(64, n);
    chkn(n, $rtoi(per(fq[0]) / 1.007));
    wr_reg(8'h09, 8'h01);
    host.measure(2, n);
    chkn(n, 0);
    done("clock");
    summarize();
  end
endmodule : tb
